// [lbhp_host_port.sv]
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - port runs as 486 local bus, 32-bit VESA local bus or PCI target.
// - one-entry write buffer lets host writes finish before the internal write retires; they wait only while it is still full.
// - address/data lines driven only while returning read data.
// - parity driven only after PCI read data; never driven in local-bus modes.
// - low host reset clears the state machine and write buffer and holds bus outputs inactive.
// - reset release captures all sixteen video memory data bits as straps if they are stable, else loads STRAP_RST.
module lbhp_host_port (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // configuration
    input wire logic [1:0] bus_sel,
    input wire logic [15:0] video_mem_data_low_bank,
    output logic [15:0] cfg_straps,
    // shared address/data and parity
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    output logic par_out,
    output logic par_oe,
    // pci control
    input wire logic [3:0] cbe_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    output logic devsel_n_out,
    output logic devsel_oe,
    output logic trdy_n_out,
    output logic trdy_oe,
    output logic stop_n_out,
    output logic stop_oe,
    // local bus control
    input wire logic [31:2] adr,
    input wire logic wr_n,
    input wire logic mio_n,
    input wire logic ads_n,
    input wire logic rdyrtn_n,
    output logic lrdy_n,
    output logic ldev_n,
    // internal write port
    output logic wr_valid,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_be_n,
    output logic wr_mem,
    input wire logic wr_ready,
    // internal read port
    output logic rd_req,
    output logic [31:0] rd_addr,
    output logic [3:0] rd_be_n,
    output logic rd_mem,
    input wire logic rd_ack,
    input wire logic [31:0] rd_data
);
    function automatic logic addr_hit(input logic [31:0] a, input logic mem);
        addr_hit = mem ? (a[31:lbhp_pkg::MEM_LSB] == lbhp_pkg::MEM_BASE)
                       : (a[15:lbhp_pkg::IO_LSB] == lbhp_pkg::IO_PAGE);
    endfunction

    lbhp_pkg::lbhp_state_t state_q;
    lbhp_pkg::lbhp_mode_t mode_q;
    logic [1:0] sel_s1, sel_s2, sel_s3;
    logic [15:0] mda_s1, mda_s2, mda_s3;
    logic rstn_prev_q;
    logic [31:0] addr_q;
    logic [3:0] be_q;
    logic mem_q;
    logic rd_busy_q;

    // pci command decode
    wire p_rd = (cbe_n == lbhp_pkg::CMD_IO_RD) || (cbe_n == lbhp_pkg::CMD_MEM_RD);
    wire p_wr = (cbe_n == lbhp_pkg::CMD_IO_WR) || (cbe_n == lbhp_pkg::CMD_MEM_WR);
    wire p_mem = cbe_n[2];
    wire p_claim = !frame_n && (p_rd || p_wr) && addr_hit(ad_in, p_mem);
    wire l_claim = !ads_n && addr_hit({adr, 2'b00}, mio_n);
    wire is_pci = (mode_q == lbhp_pkg::MODE_PCI);
    // buffer may take a new write while the old one retires
    wire wb_free = !wr_valid || wr_ready;
    wire rd_go = !rd_busy_q && !wr_valid;
    wire p_xfer = !trdy_n_out && !irdy_n;

    // pin synchronisers; straps and mode pins come from outside the bus clock
    always_ff @(posedge clk) begin
        sel_s1 <= bus_sel;
        sel_s2 <= sel_s1;
        sel_s3 <= sel_s2;
        mda_s1 <= video_mem_data_low_bank;
        mda_s2 <= mda_s1;
        mda_s3 <= mda_s2;
        rstn_prev_q <= rstn;
    end

    always_ff @(posedge clk) begin
        if (!rstn_prev_q && rstn && (mda_s2 == mda_s3)) begin
            cfg_straps <= mda_s3;
        end else if (!rstn_prev_q && rstn) begin
            cfg_straps <= lbhp_pkg::STRAP_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_q <= lbhp_pkg::MODE_486;
        end else if (state_q == lbhp_pkg::ST_IDLE && sel_s2 == sel_s3) begin
            unique case (sel_s3)
                lbhp_pkg::SEL_VL: mode_q <= lbhp_pkg::MODE_VL;
                lbhp_pkg::SEL_PCI: mode_q <= lbhp_pkg::MODE_PCI;
                default: mode_q <= lbhp_pkg::MODE_486;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= lbhp_pkg::ST_IDLE;
            ad_out <= 32'h0000_0000;
            ad_oe <= 1'b0;
            par_out <= 1'b0;
            par_oe <= 1'b0;
            devsel_n_out <= 1'b1;
            devsel_oe <= 1'b0;
            trdy_n_out <= 1'b1;
            trdy_oe <= 1'b0;
            stop_n_out <= 1'b1;
            stop_oe <= 1'b0;
            lrdy_n <= 1'b1;
            ldev_n <= 1'b1;
            wr_valid <= 1'b0;
            wr_addr <= 32'h0000_0000;
            wr_data <= 32'h0000_0000;
            wr_be_n <= 4'hf;
            wr_mem <= 1'b0;
            rd_req <= 1'b0;
            rd_busy_q <= 1'b0;
            addr_q <= 32'h0000_0000;
            be_q <= 4'hf;
            mem_q <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            if (wr_valid && wr_ready) begin
                wr_valid <= 1'b0;
            end
            unique case (state_q)
                lbhp_pkg::ST_IDLE: begin
                    if (is_pci && p_claim) begin
                        addr_q <= ad_in;
                        mem_q <= p_mem;
                        devsel_n_out <= 1'b0;
                        devsel_oe <= 1'b1;
                        trdy_oe <= 1'b1;
                        stop_oe <= 1'b1;
                        state_q <= p_wr ? lbhp_pkg::ST_P_WR : lbhp_pkg::ST_P_RD;
                    end else if (!is_pci && l_claim) begin
                        addr_q <= {adr, 2'b00};
                        be_q <= cbe_n;
                        mem_q <= mio_n;
                        ldev_n <= (mode_q != lbhp_pkg::MODE_VL);
                        state_q <= wr_n ? lbhp_pkg::ST_L_WR : lbhp_pkg::ST_L_RD;
                    end
                end
                lbhp_pkg::ST_P_WR: begin
                    if (p_xfer) begin
                        wr_valid <= 1'b1;
                        wr_addr <= addr_q;
                        wr_data <= ad_in;
                        wr_be_n <= cbe_n;
                        wr_mem <= mem_q;
                        trdy_n_out <= 1'b1;
                        stop_n_out <= 1'b1;
                        devsel_n_out <= 1'b1;
                        state_q <= lbhp_pkg::ST_P_TURN;
                    end else if (wb_free) begin
                        trdy_n_out <= 1'b0;
                        stop_n_out <= 1'b0;
                    end
                end
                lbhp_pkg::ST_P_RD: begin
                    if (rd_go) begin
                        rd_req <= 1'b1;
                        rd_busy_q <= 1'b1;
                        rd_addr <= addr_q;
                        rd_be_n <= cbe_n;
                        rd_mem <= mem_q;
                    end
                    if (rd_busy_q && rd_ack) begin
                        rd_busy_q <= 1'b0;
                        ad_out <= rd_data;
                        ad_oe <= 1'b1;
                        trdy_n_out <= 1'b0;
                        stop_n_out <= 1'b0;
                        state_q <= lbhp_pkg::ST_P_RDDATA;
                    end
                end
                lbhp_pkg::ST_P_RDDATA: begin
                    if (!irdy_n) begin
                        ad_oe <= 1'b0;
                        par_out <= ^{ad_out, cbe_n};
                        par_oe <= 1'b1;
                        trdy_n_out <= 1'b1;
                        stop_n_out <= 1'b1;
                        devsel_n_out <= 1'b1;
                        state_q <= lbhp_pkg::ST_P_TURN;
                    end
                end
                lbhp_pkg::ST_P_TURN: begin
                    par_oe <= 1'b0;
                    devsel_oe <= 1'b0;
                    trdy_oe <= 1'b0;
                    stop_oe <= 1'b0;
                    state_q <= lbhp_pkg::ST_IDLE;
                end
                lbhp_pkg::ST_L_WR: begin
                    if (wb_free) begin
                        wr_valid <= 1'b1;
                        wr_addr <= addr_q;
                        wr_data <= ad_in;
                        wr_be_n <= be_q;
                        wr_mem <= mem_q;
                        lrdy_n <= 1'b0;
                        state_q <= lbhp_pkg::ST_L_DONE;
                    end
                end
                lbhp_pkg::ST_L_RD: begin
                    if (rd_go) begin
                        rd_req <= 1'b1;
                        rd_busy_q <= 1'b1;
                        rd_addr <= addr_q;
                        rd_be_n <= be_q;
                        rd_mem <= mem_q;
                    end
                    if (rd_busy_q && rd_ack) begin
                        rd_busy_q <= 1'b0;
                        ad_out <= rd_data;
                        ad_oe <= 1'b1;
                        lrdy_n <= 1'b0;
                        state_q <= lbhp_pkg::ST_L_DONE;
                    end
                end
                lbhp_pkg::ST_L_DONE: begin
                    lrdy_n <= 1'b1;
                    // vesa cycles end on ready return, 486 cycles on our ready
                    if (mode_q != lbhp_pkg::MODE_VL || !rdyrtn_n) begin
                        ad_oe <= 1'b0;
                        ldev_n <= 1'b1;
                        state_q <= lbhp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [lbhp_host_port_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module lbhp_host_port_tb;
    localparam logic [31:0] K = 32'h5a5a0000;
    function automatic logic [31:0] exp_rd(input logic [31:0] x);
        return x ^ K;
    endfunction
    logic clk = 0, rstn = 0, frame_n = 1, irdy_n = 1, wr_n = 0, mio_n = 1, ads_n = 1;
    logic rdyrtn_n = 1, slow = 0, ok, pe, pv, lv;
    logic [1:0] bus_sel = 2'h2;
    logic [3:0] cbe_n = 4'hf, wr_be_n, rd_be_n, be = 4'h0;
    logic [4:0] wm, rb;
    logic [15:0] video_mem_data_low_bank = 16'h0, cfg_straps, s;
    logic [31:2] adr = 30'h3fffffff;
    logic [31:0] ad_in = 32'h0, ad_out, wr_addr, wr_data, rd_addr, rd_data, a, d, r, wa, wd;
    logic ad_oe, par_out, par_oe, devsel_n_out, devsel_oe, trdy_n_out, trdy_oe, stop_n_out;
    logic stop_oe, lrdy_n, ldev_n, wr_valid, wr_mem, wr_ready, rd_req, rd_mem, rd_ack;
    int bad_count = 0, checks = 0, cyc = 0, n, iw = 0;
    lbhp_host_port dut (.*);
    lbhp_mem_model mem (.*);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (wr_valid && wr_ready) begin
            wa <= wr_addr;
            wd <= wr_data;
            wm <= {wr_mem, wr_be_n};
        end
        if (rd_req) begin
            rb <= {rd_mem, rd_be_n};
        end
        if (++cyc == 5000) begin
            bad_count++;
            finish_test;
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (e !== g) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rst(input logic [15:0] v);
        rstn = 0;
        video_mem_data_low_bank = v;
        repeat (16) @(posedge clk);
        #1 rstn = 1;
        video_mem_data_low_bank = ~v;
        repeat (5) @(posedge clk);
        #1 chk("straps", v, cfg_straps);
        $display("test reset done");
    endtask
    task automatic pci(input logic [3:0] c, input logic [31:0] ad, dd);
        frame_n = 0;
        cbe_n = c;
        ad_in = ad;
        @(posedge clk);
        #1 cbe_n = be;
        ad_in = dd;
        // initiator wait states before irdy
        repeat (iw) begin
            @(posedge clk);
            #1;
        end
        frame_n = 1;
        irdy_n = 0;
        n = 0;
        do begin @(posedge clk); n++; end while (!(trdy_oe && !trdy_n_out) && n < 30);
        ok = n < 30;
        r = ad_out;
        #1 irdy_n = 1;
        ad_in = ~dd;
        @(posedge clk);
        pe = par_oe;
        pv = par_out;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic loc(input logic wr, input logic [31:0] ad, dd);
        adr = ad[31:2];
        wr_n = wr;
        ads_n = 0;
        cbe_n = be;
        ad_in = dd;
        @(posedge clk);
        #1 ads_n = 1;
        n = 0;
        lv = 1;
        pe = 0;
        pv = 0;
        do begin
            @(posedge clk);
            n++;
            lv &= ldev_n;
            pe |= par_oe;
            pv |= ad_oe;
        end while (lrdy_n && n < 30);
        ok = n < 30;
        r = ad_out;
        #1 rdyrtn_n = 0;
        @(posedge clk);
        #1 rdyrtn_n = 1;
        ad_in = ~dd;
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        a = $urandom(32'haeb2);
        s = 16'($urandom);
        rst(s);
        for (int i = 0; i < 8; i++) begin
            slow = i[0];
            iw = (i == 2) ? 2 : int'($urandom % 3);
            be = 4'($urandom);
            a = i > 5 ? {22'h0, 8'($urandom), 2'h0} : {8'h0a, 22'($urandom), 2'h0};
            d = $urandom;
            pci(i > 5 ? lbhp_pkg::CMD_IO_WR : lbhp_pkg::CMD_MEM_WR, a, d);
            chk("write claimed", 1, ok);
            chk("write parity off", 0, pe);
            pci(i > 5 ? lbhp_pkg::CMD_IO_RD : lbhp_pkg::CMD_MEM_RD, a, d);
            chk("write data", d, wd);
            chk("write addr", a[31:2], wa[31:2]);
            chk("write enables", {(i <= 5), be}, wm);
            chk("read enables", {(i <= 5), be}, rb);
            chk("read data", exp_rd(a), r);
            chk("parity", ^{r, be}, pv);
            chk("parity on", 1, pe);
        end
        $display("test pci done");
        iw = 0;
        pci(4'h0, a, d);
        chk("other command", 0, ok);
        pci(lbhp_pkg::CMD_MEM_WR, 32'h0b000000, d);
        chk("window miss", 0, ok);
        $display("test pci refusal done");
        for (int m = 0; m < 2; m++) begin
            bus_sel = m ? lbhp_pkg::SEL_486 : lbhp_pkg::SEL_VL;
            repeat (4) @(posedge clk);
            #1 a = {8'h0a, 22'($urandom), 2'h0};
            d = $urandom;
            be = 4'($urandom);
            loc(1, a, d);
            chk("local write", 1, ok);
            chk("local write drive", 0, pv);
            chk("local write parity", 0, pe);
            loc(0, a, d);
            chk("local read", exp_rd(a), r);
            chk("local read drive", 1, pv);
            chk("local read parity", 0, pe);
            chk("local wdata", d, wd);
            chk("local write enables", {1'b1, be}, wm);
            chk("local read enables", {1'b1, be}, rb);
            chk("device select", m, lv);
            $display("test local mode %0d done", m);
        end
        rst(~s);
        finish_test;
    end
endmodule
`default_nettype wire

// [lbhp_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module lbhp_mem_model (
    // clock, reset and pacing
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    // internal side of the host port
    input wire logic rd_req,
    input wire logic [31:0] rd_addr,
    output logic wr_ready,
    output logic rd_ack,
    output logic [31:0] rd_data
);
    logic [2:0] wait_q;
    logic tog_q;
    // slow sink takes writes every other cycle
    assign wr_ready = !slow || tog_q;
    always_ff @(posedge clk) begin
        tog_q <= !tog_q && rstn;
        rd_ack <= rstn && wait_q == 3'h1;
        rd_data <= wait_q == 3'h1 ? rd_addr ^ 32'h5a5a0000 : ~rd_data;
        if (!rstn) wait_q <= 3'h0;
        else if (rd_req) wait_q <= slow ? 3'h5 : 3'h1;
        else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
    end
endmodule
`default_nettype wire

// [lbhp_pkg.sv]
`default_nettype none
package lbhp_pkg;
    // bus selection pin codes
    localparam logic [1:0] SEL_486 = 2'h0;
    localparam logic [1:0] SEL_VL = 2'h1;
    localparam logic [1:0] SEL_PCI = 2'h2;
    // pci target commands
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    // address decode windows
    localparam int MEM_LSB = 24;
    localparam logic [7:0] MEM_BASE = 8'h0a;
    localparam int IO_LSB = 10;
    localparam logic [5:0] IO_PAGE = 6'h00;
    localparam logic [15:0] STRAP_RST = 16'h0000;
    typedef enum logic [1:0] {MODE_486, MODE_VL, MODE_PCI} lbhp_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_P_WR, ST_P_RD, ST_P_RDDATA, ST_P_TURN, ST_L_WR, ST_L_RD, ST_L_DONE
    } lbhp_state_t;
endpackage
`default_nettype wire

// [lbhp_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module lbhp_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pci side
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic devsel_n_out,
    input wire logic devsel_oe,
    input wire logic trdy_n_out,
    input wire logic trdy_oe,
    input wire logic stop_n_out,
    input wire logic stop_oe,
    // data, parity and local ready
    input wire logic ad_oe,
    input wire logic par_oe,
    input wire logic lrdy_n,
    // internal ports
    input wire logic wr_valid,
    input wire logic rd_req,
    input wire logic rd_ack,
    // configuration
    input wire logic [15:0] cfg_straps
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_reset_idle: assert property (disable iff (1'b0) !rstn |=>
        !ad_oe && !par_oe && devsel_n_out && !wr_valid && !rd_req) else $error("reset outputs");
    a_data_after_ack: assert property ($rose(ad_oe) |-> $past(rd_ack))
        else $error("read data without ack");
    a_par_after_data: assert property ($rose(par_oe) |-> $past(ad_oe))
        else $error("parity without read data");
    a_par_one_cycle: assert property (par_oe |=> !par_oe)
        else $error("parity too long");
    a_straps_hold: assert property ($past(rstn) && $past(rstn, 2) |-> $stable(cfg_straps))
        else $error("straps changed");
    a_claim_frame: assert property ($fell(devsel_n_out) |-> !$past(frame_n))
        else $error("claim without frame");
    a_trdy_stands: assert property (trdy_oe && !trdy_n_out && irdy_n |=> !trdy_n_out)
        else $error("trdy dropped early");
    a_stop_with_trdy: assert property (trdy_oe |-> stop_n_out == trdy_n_out)
        else $error("stop apart from trdy");
    a_oe_group: assert property (devsel_oe == trdy_oe && stop_oe == trdy_oe)
        else $error("target enables apart");
    a_lrdy_pulse: assert property (!lrdy_n |=> lrdy_n)
        else $error("local ready too long");
endmodule
bind lbhp_host_port lbhp_properties chk (.*);
`default_nettype wire
